/* fieldbus_connection_watchdog.sv */
// connection supervision for cyclic exchange and one modbus channel
// Notes on behaviour
// RULE1 - drive watches both link loss and message timeouts continuously; here link loss counts only while a timeout is nonzero
// RULE2 - link loss is seen only from the drive's own port state
// RULE3 - cyclic timeout is 0..10000 ms, 0 disables, default 0
// RULE4 - cyclic supervision starts at the first cyclic message after setup
// RULE5 - after a cyclic timeout, re-arm only on the next cyclic message
// RULE6 - channel timeout supervises the channel that wrote it, 0..10000 ms
// RULE7 - silent supervised channel halts processing with class 2 error
// RULE8 - with supervision off, an interrupted link gives no error
// RULE9 - with supervision off, the last command keeps executing
// RULE10 - master should keep supervision on except for troubleshooting
// RULE11 - armed timers restart per message and expire at the interval
`timescale 1ns/100ps
module fieldbus_connection_watchdog
	import watchdog_pkg::*;
#(
	parameter int TICK_DIV = watchdog_pkg::TICK_CYCLES
)
(
	// clock and reset
	input  wire logic                           mclk_i,
	input  wire logic                           rst_n_i,
	// parameter access from the protocol stack
	input  wire logic                           par_wr_i,
	input  wire logic                           par_rd_i,
	input  wire logic [15:0]                    par_addr_i,
	input  wire logic [15:0]                    par_wdata_i,
	input  wire logic [watchdog_pkg::CHAN_W-1:0] par_chan_i,
	output logic [15:0]                         par_rdata_o,
	output logic                                par_ack_o,
	output logic                                par_err_o,
	// message events
	input  wire logic                           cyclic_msg_i,
	input  wire logic                           chan_msg_i,
	input  wire logic [watchdog_pkg::CHAN_W-1:0] chan_id_i,
	// physical port link state and error clear
	input  wire logic                           link_up_i,
	input  wire logic                           err_clear_i,
	// supervision results
	output logic                                cyclic_timeout_o,
	output logic                                chan_timeout_o,
	output logic                                link_lost_o,
	output logic                                halt_o,
	output logic [1:0]                          err_class_o
);
	import watchdog_pkg::*;

	typedef struct packed
	{
		logic [TICK_CNT_W-1:0] div;
		logic                  tick;
		logic [15:0]           cyc_limit;
		logic [15:0]           chan_limit;
		logic [CHAN_W-1:0]     chan_owner;
		logic                  chan_arm;
		logic                  link_q;
		logic [15:0]           rdata;
		logic                  ack;
		logic                  perr;
		logic                  cyc_to;
		logic                  chan_to;
		logic                  link_lost;
		logic                  halt;
		logic [1:0]            err_class;
	} wd_s;

	wd_s st;
	wd_s next_st;

	logic cyc_expire;
	logic chan_expire;
	logic cyc_cfg_wr;
	logic chan_cfg_wr;
	logic chan_kick;

	// range check shared by both timeout settings
	function automatic logic in_range(input logic [15:0] v);
		in_range = (v <= TIMEOUT_MAX);
	endfunction

	// a falling port link counts only while some supervision is enabled
	function automatic logic link_drop(input logic was_up, input logic is_up,
		input logic [15:0] cyc_lim, input logic [15:0] chan_lim);
		link_drop = was_up && !is_up
			&& (cyc_lim != 16'h0000 || chan_lim != 16'h0000);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write strobes and channel qualification

	assign cyc_cfg_wr  = par_wr_i && par_addr_i == CYCLIC_TIMEOUT_ADDR
		&& in_range(par_wdata_i);
	assign chan_cfg_wr = par_wr_i && par_addr_i == CHANNEL_TIMEOUT_ADDR
		&& in_range(par_wdata_i);
	// only messages on the channel that set the limit keep it alive
	assign chan_kick   = chan_msg_i && chan_id_i == st.chan_owner; // [RULE6]

	////////////////////////////////////////////////////////////////////////
	// timers

	// a config write disarms; the next cyclic message arms again
	ms_timer u_cyclic
	(
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.tick_i   (st.tick),
		.arm_i    (1'b0),
		.disarm_i (cyc_cfg_wr),
		.kick_i   (cyclic_msg_i), // [RULE4] [RULE5]
		.limit_i  (st.cyc_limit), // [RULE3]
		.armed_o  (),
		.expire_o (cyc_expire)
	);

	// arming waits a cycle: a timer fed the old zero limit would disarm
	ms_timer u_channel
	(
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.tick_i   (st.tick),
		.arm_i    (st.chan_arm), // [RULE6]
		.disarm_i (1'b0),
		.kick_i   (chan_kick),
		.limit_i  (st.chan_limit),
		.armed_o  (),
		.expire_o (chan_expire)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_st = st;
		next_st.ack  = 1'b0;
		next_st.perr = 1'b0;
		// arm the channel timer a cycle late, when the new limit stands
		next_st.chan_arm = chan_cfg_wr && par_wdata_i != 16'h0000;
		// 1 ms enable from a free running divider
		if (st.div == TICK_CNT_W'(TICK_DIV - 1))
		begin
			next_st.div  = '0;
			next_st.tick = 1'b1;
		end
		else
		begin
			next_st.div  = st.div + TICK_CNT_W'(1);
			next_st.tick = 1'b0;
		end
		// out of range writes are refused and leave the setting alone
		if (par_wr_i)
		begin
			next_st.ack = 1'b1;
			if (cyc_cfg_wr)
				next_st.cyc_limit = par_wdata_i; // [RULE3]
			else if (chan_cfg_wr)
			begin
				next_st.chan_limit = par_wdata_i; // [RULE6]
				next_st.chan_owner = par_chan_i; // [RULE6]
			end
			else
				next_st.perr = 1'b1;
		end
		else if (par_rd_i)
		begin
			next_st.ack = 1'b1;
			unique case (par_addr_i)
				CYCLIC_TIMEOUT_ADDR:  next_st.rdata = st.cyc_limit;
				CHANNEL_TIMEOUT_ADDR: next_st.rdata = st.chan_limit;
				default:
				begin
					next_st.rdata = 16'h0000;
					next_st.perr  = 1'b1;
				end
			endcase
		end
		// link loss only at our own port; a switch hides it [RULE2]
		next_st.link_q = link_up_i;
		if (link_drop(st.link_q, link_up_i, st.cyc_limit, st.chan_limit))
			next_st.link_lost = 1'b1; // [RULE1] [RULE8]
		// sticky errors; without supervision none arise [RULE8] [RULE9]
		if (cyc_expire)
			next_st.cyc_to = 1'b1; // [RULE1]
		if (chan_expire)
		begin
			next_st.chan_to   = 1'b1;
			next_st.halt      = 1'b1; // [RULE7]
			next_st.err_class = ERR_CLASS_CHANNEL; // [RULE7]
		end
		// clear loses against a same cycle event
		if (err_clear_i)
		begin
			next_st.cyc_to    = cyc_expire;
			next_st.chan_to   = chan_expire;
			next_st.halt      = chan_expire;
			next_st.err_class = chan_expire ? ERR_CLASS_CHANNEL : 2'h0;
			next_st.link_lost = link_drop(st.link_q, link_up_i,
				st.cyc_limit, st.chan_limit);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			st            <= '0;
			st.cyc_limit  <= TIMEOUT_RESET;
			st.chan_limit <= TIMEOUT_RESET;
		end
		else
			st <= next_st;
	end

	// outputs straight from flip-flops
	assign par_rdata_o      = st.rdata;
	assign par_ack_o        = st.ack;
	assign par_err_o        = st.perr;
	assign cyclic_timeout_o = st.cyc_to;
	assign chan_timeout_o   = st.chan_to;
	assign link_lost_o      = st.link_lost;
	assign halt_o           = st.halt;
	assign err_class_o      = st.err_class;
endmodule

/* watchdog_pkg.sv */
// shared constants for the fieldbus connection watchdog
package watchdog_pkg;
	// register offsets (parameter addresses)
	localparam logic [15:0] CHANNEL_TIMEOUT_ADDR = 16'h160c;
	localparam logic [15:0] CYCLIC_TIMEOUT_ADDR  = 16'h190e;
	// reset values and limits
	localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
	localparam logic [15:0] TIMEOUT_MAX   = 16'h2710;
	localparam logic [1:0]  ERR_CLASS_CHANNEL = 2'h2;
	// timebase: one millisecond at the 20 MHz clock
	localparam int CLK_HZ        = 20000000;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_CNT_W    = 15;
	// channel identifier width
	localparam int CHAN_W        = 4;
endpackage

/* ms_timer.sv */
// armed millisecond timer that restarts on each qualifying message
`timescale 1ns/100ps
module ms_timer
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// control
	input  wire logic        tick_i,
	input  wire logic        arm_i,
	input  wire logic        disarm_i,
	input  wire logic        kick_i,
	input  wire logic [15:0] limit_i,
	// status
	output logic             armed_o,
	output logic             expire_o
);
	typedef struct packed
	{
		logic        armed;
		logic        expire;
		logic [15:0] count;
	} timer_s;

	timer_s st;
	timer_s next_st;

	// count ms while armed; a kick or arm restarts from zero
	always_comb
	begin
		next_st = st;
		next_st.expire = 1'b0;
		if (disarm_i || limit_i == 16'h0000)
		begin
			next_st.armed = 1'b0;
			next_st.count = 16'h0000;
		end
		else if (arm_i || kick_i)
		begin
			next_st.armed = 1'b1;
			next_st.count = 16'h0000; // [RULE11]
		end
		else if (st.armed && tick_i)
		begin
			if (st.count + 16'h0001 >= limit_i)
			begin
				// expired: stay unarmed until the next kick or arm
				next_st.expire = 1'b1; // [RULE11]
				next_st.armed  = 1'b0;
				next_st.count  = 16'h0000;
			end
			else
				next_st.count = st.count + 16'h0001;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign armed_o  = st.armed;
	assign expire_o = st.expire;
endmodule

/* watchdog_checker.sv */
// assertions on the watchdog parameter port and supervision flags
`timescale 1ns/100ps
module watchdog_checker
	import watchdog_pkg::*;
(
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	// parameter access
	input wire logic        par_wr_i,
	input wire logic        par_rd_i,
	input wire logic [15:0] par_addr_i,
	input wire logic [15:0] par_wdata_i,
	input wire logic [15:0] par_rdata_o,
	input wire logic        par_ack_o,
	input wire logic        par_err_o,
	// supervision
	input wire logic        link_up_i,
	input wire logic        err_clear_i,
	input wire logic        cyclic_timeout_o,
	input wire logic        chan_timeout_o,
	input wire logic        link_lost_o,
	input wire logic        halt_o,
	input wire logic [1:0]  err_class_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////
	// address decode, so unmapped reads can be told apart
	wire mapped = par_addr_i == CHANNEL_TIMEOUT_ADDR
		|| par_addr_i == CYCLIC_TIMEOUT_ADDR;
	a_ack_follows: assert property (
		(par_wr_i || par_rd_i) |=> par_ack_o)
		else $error("request not acknowledged");
	a_ack_cause: assert property (
		par_ack_o |-> $past(par_wr_i) || $past(par_rd_i))
		else $error("ack without request");
	a_err_range: assert property (
		par_wr_i && par_wdata_i > TIMEOUT_MAX |=> par_err_o)
		else $error("oversized value accepted");
	a_unmapped_read: assert property (
		par_rd_i && !par_wr_i && !mapped
		|=> par_err_o && par_rdata_o == 16'h0000)
		else $error("bad unmapped read");
	a_class_halt: assert property (
		err_class_o == (halt_o ? ERR_CLASS_CHANNEL : 2'h0))
		else $error("error class wrong");
	a_halt_cause: assert property (
		$rose(halt_o) |-> chan_timeout_o)
		else $error("halt without channel timeout");
	a_link_cause: assert property (
		$rose(link_lost_o) |-> !$past(link_up_i))
		else $error("link loss while port up");
	a_sticky_flag: assert property (
		cyclic_timeout_o && !err_clear_i |=> cyclic_timeout_o)
		else $error("timeout flag dropped");
	c_halt: cover property ($rose(halt_o));
	c_cyclic: cover property ($rose(cyclic_timeout_o));
	c_link: cover property ($rose(link_lost_o));
endmodule

/* modbus_master_model.sv */
// behavioural master: periodic cyclic and channel message events
`timescale 1ns/100ps
module modbus_master_model
#(
	parameter int GAP = 30
)
(
	// clock and traffic enables
	input  wire logic mclk_i,
	input  wire logic cyc_en_i,
	input  wire logic chn_en_i,
	// message events
	output logic      cyc_o = 1'b0,
	output logic      chn_o = 1'b0
);
	int n = 0;
	// one message of each kind per GAP cycles keeps supervision fed
	always @(posedge mclk_i)
	begin
		n = (n + 1) % GAP;
		cyc_o <= #0.5 cyc_en_i && n == 0;
		chn_o <= #0.5 chn_en_i && n == GAP / 2;
	end
endmodule

/* tb_fieldbus_connection_watchdog.sv */
// self-checking bench for the fieldbus connection watchdog
`timescale 1ns/100ps
module tb_fieldbus_connection_watchdog;
	import watchdog_pkg::*;
	logic        mclk_i = 0, rst_n_i = 0, par_wr_i = 0, par_rd_i = 0;
	logic [15:0] par_addr_i = '0, par_wdata_i = '0, par_rdata_o;
	logic [3:0]  par_chan_i = '0, chan_id_i = '0;
	logic        cyclic_msg_i, chan_msg_i, link_up_i = 1, err_clear_i = 0;
	logic        par_ack_o, par_err_o, cyclic_timeout_o, chan_timeout_o;
	logic        link_lost_o, halt_o, cyc_en = 0, chn_en = 0;
	logic [1:0]  err_class_o;
	logic [15:0] lim [2] = '{16'h0000, 16'h0000};
	logic [15:0] exp_q [$];
	int          fails = 0, checked = 0, c;
	always #25 mclk_i = ~mclk_i;
	// 1 ms shrinks to 10 cycles
	fieldbus_connection_watchdog #(.TICK_DIV(10))
		fieldbus_connection_watchdog_i (.*);
	modbus_master_model modbus_master_model_i (.mclk_i, .cyc_en_i(cyc_en),
		.chn_en_i(chn_en), .cyc_o(cyclic_msg_i), .chn_o(chan_msg_i));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	// one access; the model keeps the stored limits and queues the
	// expected read word, then an idle cycle parts it from the next
	task acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
		logic m, e;
		m = a == CHANNEL_TIMEOUT_ADDR || a == CYCLIC_TIMEOUT_ADDR;
		e = !m || (wr && d > TIMEOUT_MAX);
		if (!wr)
			exp_q.push_back(m ? lim[a == CYCLIC_TIMEOUT_ADDR] : 16'h0000);
		if (wr && !e)
			lim[a == CYCLIC_TIMEOUT_ADDR] = d;
		{par_wr_i, par_rd_i, par_addr_i, par_wdata_i} = {wr, !wr, a, d};
		cyc(1);
		chk(par_ack_o, 1'b1);
		chk(par_err_o, e);
		if (!wr)
			chk(par_rdata_o, exp_q.pop_front());
		{par_wr_i, par_rd_i} = 2'h0;
		cyc(1);
	endtask
	// bounded wait: 0 cyclic timeout, 1 channel timeout, 2 cyclic message
	task wait_flag(input int s, input int bound);
		c = 0;
		while ((s == 0 ? cyclic_timeout_o : s == 1 ? chan_timeout_o
			: cyclic_msg_i) !== 1'b1)
		begin
			cyc(1);
			c++;
			if (c > bound)
			begin
				fails++;
				print_verdict();
			end
		end
	endtask
	task clear;
		err_clear_i = 1;
		cyc(1);
		err_clear_i = 0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(90070));
		cyc(16);
		rst_n_i = 1;
		acc(0, CHANNEL_TIMEOUT_ADDR, 0);
		acc(0, CYCLIC_TIMEOUT_ADDR, 0);
		acc(0, 16'h1234, 0);
		link_up_i = 0;
		cyc(5);
		chk(link_lost_o, 0);
		chk(halt_o, 0);
		link_up_i = 1;
		acc(1, CYCLIC_TIMEOUT_ADDR, 16'(($urandom % 10000) + 1));
		acc(1, CYCLIC_TIMEOUT_ADDR, TIMEOUT_MAX + 16'h0001);
		acc(0, CYCLIC_TIMEOUT_ADDR, 0);
		acc(1, CYCLIC_TIMEOUT_ADDR, 16'h0005);
		$display("registers done");
		cyc(100);
		chk(cyclic_timeout_o, 0);
		for (int i = 0; i < 2; i++)
		begin
			cyc_en = 1;
			cyc(i ? 1 : 200);
			chk(cyclic_timeout_o, 0);
			wait_flag(2, 40);
			cyc_en = 0;
			wait_flag(0, 60);
			chk(c >= 39 && c <= 53, 1);
			cyc(3);
			chk(cyclic_timeout_o, 1);
			chk(halt_o, 0);
			clear();
			cyc(100);
			chk(cyclic_timeout_o, 0);
		end
		$display("cyclic done");
		par_chan_i = 4'h5;
		acc(1, CHANNEL_TIMEOUT_ADDR, 16'h0005);
		chan_id_i = 4'h7;
		chn_en = 1;
		wait_flag(1, 60);
		chk(halt_o, 1);
		chk(err_class_o, ERR_CLASS_CHANNEL);
		clear();
		chk(halt_o, 0);
		chk(err_class_o, 2'h0);
		chan_id_i = 4'h5;
		cyc(200);
		chk(chan_timeout_o, 0);
		link_up_i = 0;
		cyc(3);
		chk(link_lost_o, 1);
		$display("channel done");
		print_verdict();
	end
endmodule
bind fieldbus_connection_watchdog watchdog_checker watchdog_checker_i (.*);
